// ---- src/ctrl_stream_pkg.sv ----
/*
 Shared constants of the control stream source: bit timing, frame layouts,
 register map and the frame check functions.
 Assumes a 200 MHz core clock and 128 Mbit/s streams.
*/
package ctrl_stream_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_MHZ = 200;
  localparam int BIT_MHZ = 128;
  localparam int EPOCH_MS = 10;
  localparam int EPOCH_BITS = EPOCH_MS * BIT_MHZ * 1000;
  localparam int ACC_W = 8;
  localparam logic [ACC_W-1:0] ACC_STEP = ACC_W'(BIT_MHZ);
  localparam logic [ACC_W-1:0] ACC_WRAP = ACC_W'(CLK_MHZ);
  localparam int ECNT_W = 21;
  localparam int GAP_BITS = 4;
  localparam int CRC_BITS = 4;

  // ----------------------------------------------------------------
  // Frame layouts
  // ----------------------------------------------------------------
  localparam int PAY_W = 40;
  localparam int LEN_W = 6;
  localparam logic [LEN_W-1:0] DUMP_LEN = 6'h1b;
  localparam logic [LEN_W-1:0] PHASE_LEN = 6'h28;
  localparam int TC_IDP_SLOT = 1;
  localparam int TC_SEED0_SLOT = 2;
  localparam int TC_SEED1_SLOT = 10;
  localparam int TC_END_SLOT = 18;
  localparam logic [2:0] CMD_BLOCK_RESET = 3'h6;
  localparam logic [2:0] CMD_SYNC_TEST = 3'h7;

  // ----------------------------------------------------------------
  // Register map (byte addresses) and reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_SEEDS = 8'h04;
  localparam logic [7:0] REG_DUMP = 8'h08;
  localparam logic [7:0] REG_PHASE = 8'h0c;
  localparam logic [7:0] REG_PSEL = 8'h10;
  localparam logic [7:0] REG_ACTION = 8'h14;
  localparam logic [7:0] REG_STATUS = 8'h18;
  localparam logic [7:0] REG_SRCID = 8'h1c;
  localparam logic [31:0] RST_WORD = 32'h0000_0000;
  localparam int ACT_DUMP = 0;
  localparam int ACT_PHASE = 1;
  localparam int ACT_TRIG = 2;

  // ----------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------
  function automatic logic [3:0] crc4_step(input logic [3:0] c, input logic b);
    crc4_step = {c[2], c[1], c[0] ^ c[3], b ^ c[3]};
  endfunction

  function automatic logic [3:0] crc4_of(input logic [PAY_W-1:0] d,
                                         input logic [LEN_W-1:0] n);
    logic [3:0] c;
    c = 4'h0;
    for (int i = 0; i < PAY_W + CRC_BITS; i++) begin
      if (i < int'(n))
        c = crc4_step(c, d[i]);
      else if (i < int'(n) + CRC_BITS)
        c = crc4_step(c, 1'b0);
    end
    crc4_of = c;
  endfunction

  function automatic logic [31:0] byte_merge(input logic [31:0] old,
                                             input logic [31:0] din,
                                             input logic [3:0] sel);
    for (int i = 0; i < 4; i++)
      byte_merge[8*i +: 8] = sel[i] ? din[8*i +: 8] : old[8*i +: 8];
  endfunction

endpackage

// ---- src/frame_serializer.sv ----
/*
 Serialiser for one CRC-protected frame stream: start bit, payload LSB
 first, four check bits highest first, then four preamble bits.
 Assumes bit_en is a one-cycle pulse per bit slot.
*/
`timescale 1ns/100ps
module frame_serializer
  import ctrl_stream_pkg::*;
(
  input wire logic core_clk,
  input wire logic srst,
  input wire logic bit_en,
  input wire logic preamble,
  input wire logic load,
  input wire logic [PAY_W-1:0] payload,
  input wire logic [LEN_W-1:0] len,
  output logic busy,
  output logic bit_out
);

  logic [PAY_W-1:0] pay_ff;
  logic [LEN_W-1:0] len_ff;
  logic [3:0] crc_ff;
  logic [LEN_W:0] pos_ff;
  logic act_ff;
  logic [LEN_W:0] crc_pos;
  logic [LEN_W:0] gap_pos;
  logic [LEN_W:0] last_pos;
  logic in_pay;
  logic in_crc;
  logic in_gap;

  // ----------------------------------------------------------------
  // Slot decode
  // ----------------------------------------------------------------
  assign crc_pos = {1'b0, len_ff} + 7'h01;
  assign gap_pos = crc_pos + 7'(CRC_BITS);
  assign last_pos = gap_pos + 7'(GAP_BITS - 1);
  assign in_pay = act_ff && pos_ff != 7'h00 && pos_ff < crc_pos;
  assign in_crc = act_ff && pos_ff >= crc_pos && pos_ff < gap_pos;
  assign in_gap = act_ff && pos_ff >= gap_pos;
  assign busy = act_ff;

  always_comb begin
    if (!act_ff)
      bit_out = preamble;
    else if (pos_ff == 7'h00)
      bit_out = 1'b1;
    else if (in_pay)
      bit_out = pay_ff[6'(pos_ff - 7'h01)];
    else if (in_crc)
      // Last register stage leaves first, so the far end sees a zero remainder
      bit_out = crc_ff[2'(gap_pos - 7'h01 - pos_ff)];
    else
      bit_out = preamble;
  end

  // ----------------------------------------------------------------
  // Frame state
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (srst) begin
      act_ff <= 1'b0;
      pos_ff <= '0;
      pay_ff <= '0;
      len_ff <= '0;
      crc_ff <= 4'h0;
    end else if (load && !act_ff) begin
      act_ff <= 1'b1;
      pos_ff <= '0;
      pay_ff <= payload;
      len_ff <= len;
      crc_ff <= crc4_of(payload, len);
    end else if (bit_en && act_ff) begin
      pos_ff <= pos_ff + 7'h01;
      if (pos_ff == last_pos)
        act_ff <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  logic [3:0] resid;
  always_comb begin
    resid = 4'h0;
    for (int i = 0; i < PAY_W; i++)
      if (i < int'(len_ff))
        resid = crc4_step(resid, pay_ff[i]);
    for (int i = CRC_BITS - 1; i >= 0; i--)
      resid = crc4_step(resid, crc_ff[i]);
  end

  chk_crc_residue: assert property (@(posedge core_clk) disable iff (srst)
    act_ff |-> resid == 4'h0)
    else $error("frame check bits do not give a zero remainder");
  chk_lsb_first: assert property (@(posedge core_clk) disable iff (srst)
    (act_ff && pos_ff == 7'h01) |-> bit_out == pay_ff[0])
    else $error("first payload bit is not the least significant");
  chk_gap_quiet: assert property (@(posedge core_clk) disable iff (srst)
    in_gap |-> bit_out == preamble)
    else $error("gap after frame not preamble");

endmodule

// ---- src/ctrl_stream_source.sv ----
/*
 Control stream source: generates the time reference, dump control and
 phase model bit streams from settings written over a Wishbone slave.
 Assumes classic single-cycle Wishbone masters and a far-end receiver.
*/
`timescale 1ns/100ps
// Function
// - Tick bit marks epoch every 10 ms
// - Identifier-present bit follows each tick
// - Two 8-bit lane seeds, unchecked
// - 128 Mbit/s, words sent LSB first
// - 110 parameter carries source identity
// - Four-bit CRC over command to parameter
// - Trigger is second 1 after frame
// - At least four preamble bits between frames
// - Phase model 32-bit, offset valid next tick
// - Rate term in 64 MHz cycles
// - Phase preambles epoch aligned, no overlap
// - CRC cleared, zero padded, highest first
// - Idle streams carry preamble pattern
module ctrl_stream_source
  import ctrl_stream_pkg::*;
#(
  parameter int EPOCH_LEN = EPOCH_BITS
)
(
  input wire logic core_clk,
  input wire logic srst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic time_ref_stream,
  output logic dump_control_stream,
  output logic phase_model_stream
);

  typedef enum logic [1:0] {TRG_IDLE, TRG_WAIT, TRG_ONE, TRG_TWO} trg_state_t;

  logic [ACC_W-1:0] acc_ff;
  logic bit_en_ff;
  logic [ECNT_W-1:0] ecnt_ff;
  logic [31:0] ctrl_ff;
  logic [31:0] seeds_ff;
  logic [31:0] dump_ff;
  logic [31:0] phase_ff;
  logic [31:0] psel_ff;
  logic [31:0] srcid_ff;
  logic [31:0] dat_o_ff;
  logic ack_ff;
  logic [15:0] seed_lat_ff;
  logic idp_lat_ff;
  logic sync_ff;
  logic dump_req_ff;
  logic phase_req_ff;
  logic tc_ff;
  logic dc_ff;
  logic pm_ff;
  trg_state_t trg_ff;
  trg_state_t nxt_trg;
  logic dump_busy;
  logic phase_busy;

  // ----------------------------------------------------------------
  // Bit slot timing
  // ----------------------------------------------------------------
  // Carry bit: the sum can pass the accumulator width
  logic [ACC_W:0] acc_sum;
  logic wrap;
  logic epoch_slot;
  logic preamble;
  assign acc_sum = {1'b0, acc_ff} + {1'b0, ACC_STEP};
  assign wrap = acc_sum >= {1'b0, ACC_WRAP};
  assign epoch_slot = ecnt_ff == '0;
  assign preamble = ecnt_ff[0];

  always_ff @(posedge core_clk) begin
    if (srst) begin
      acc_ff <= '0;
      bit_en_ff <= 1'b0;
    end else begin
      acc_ff <= wrap ? ACC_W'(acc_sum - {1'b0, ACC_WRAP}) : ACC_W'(acc_sum);
      bit_en_ff <= wrap;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst)
      ecnt_ff <= '0;
    else if (bit_en_ff)
      ecnt_ff <= (ecnt_ff == ECNT_W'(EPOCH_LEN - 1)) ? '0 : ecnt_ff + 1'b1;
  end

  // ----------------------------------------------------------------
  // Wishbone slave
  // ----------------------------------------------------------------
  logic req;
  logic wr;
  logic [31:0] rd_mux;
  logic [31:0] status_word;
  logic act_wr;
  assign req = wb_cyc_i && wb_stb_i;
  assign wr = req && wb_we_i && ack_ff;
  assign act_wr = wr && wb_adr_i == REG_ACTION && wb_sel_i[0];
  assign status_word = {26'h0, sync_ff, trg_ff != TRG_IDLE, dump_busy, phase_busy,
                        phase_req_ff, dump_req_ff};
  assign rd_mux = (wb_adr_i == REG_CTRL) ? ctrl_ff :
                  (wb_adr_i == REG_SEEDS) ? seeds_ff :
                  (wb_adr_i == REG_DUMP) ? dump_ff :
                  (wb_adr_i == REG_PHASE) ? phase_ff :
                  (wb_adr_i == REG_PSEL) ? psel_ff :
                  (wb_adr_i == REG_STATUS) ? status_word :
                  (wb_adr_i == REG_SRCID) ? srcid_ff : RST_WORD;
  assign wb_ack_o = ack_ff;
  assign wb_dat_o = dat_o_ff;

  always_ff @(posedge core_clk) begin
    if (srst) begin
      ack_ff <= 1'b0;
      dat_o_ff <= RST_WORD;
    end else begin
      ack_ff <= req && !ack_ff;
      if (req && !ack_ff)
        dat_o_ff <= rd_mux;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      ctrl_ff <= RST_WORD;
      seeds_ff <= RST_WORD;
      dump_ff <= RST_WORD;
      phase_ff <= RST_WORD;
      psel_ff <= RST_WORD;
      srcid_ff <= RST_WORD;
    end else if (wr) begin
      if (wb_adr_i == REG_CTRL)
        ctrl_ff <= byte_merge(ctrl_ff, wb_dat_i, wb_sel_i) & 32'h0000_0001;
      if (wb_adr_i == REG_SEEDS)
        seeds_ff <= byte_merge(seeds_ff, wb_dat_i, wb_sel_i) & 32'h0000_ffff;
      if (wb_adr_i == REG_DUMP)
        dump_ff <= byte_merge(dump_ff, wb_dat_i, wb_sel_i) & 32'h07ff_ffff;
      if (wb_adr_i == REG_PHASE)
        phase_ff <= byte_merge(phase_ff, wb_dat_i, wb_sel_i);
      if (wb_adr_i == REG_PSEL)
        psel_ff <= byte_merge(psel_ff, wb_dat_i, wb_sel_i) & 32'h0000_00ff;
      if (wb_adr_i == REG_SRCID)
        srcid_ff <= byte_merge(srcid_ff, wb_dat_i, wb_sel_i) & 32'h0000_ffff;
    end
  end

  // ----------------------------------------------------------------
  // Time reference stream
  // ----------------------------------------------------------------
  logic tc_bit;
  assign tc_bit = epoch_slot ? 1'b1 :
                  (ecnt_ff == ECNT_W'(TC_IDP_SLOT)) ? idp_lat_ff :
                  (ecnt_ff < ECNT_W'(TC_END_SLOT)) ?
                    seed_lat_ff[4'(ecnt_ff - ECNT_W'(TC_SEED0_SLOT))] : preamble;

  always_ff @(posedge core_clk) begin
    if (srst) begin
      seed_lat_ff <= 16'h0000;
      idp_lat_ff <= 1'b0;
      tc_ff <= 1'b0;
    end else if (bit_en_ff) begin
      tc_ff <= tc_bit;
      if (epoch_slot) begin
        seed_lat_ff <= seeds_ff[15:0];
        idp_lat_ff <= ctrl_ff[0];
      end
    end
  end

  // ----------------------------------------------------------------
  // Dump control and phase model frames
  // ----------------------------------------------------------------
  logic [15:0] dump_param;
  logic [PAY_W-1:0] dump_pay;
  logic [PAY_W-1:0] phase_pay;
  logic dump_bit;
  logic phase_bit;
  logic dump_go;
  logic phase_go;
  assign dump_param = (dump_ff[2:0] == CMD_BLOCK_RESET) ? srcid_ff[15:0] :
                      dump_ff[26:11];
  assign dump_pay = {13'h0, dump_param, dump_ff[10:0]};
  assign phase_pay = {phase_ff[31:16], phase_ff[15:0], psel_ff[7:0]};
  assign dump_go = dump_req_ff && trg_ff == TRG_IDLE && bit_en_ff && preamble;
  assign phase_go = phase_req_ff && bit_en_ff && preamble;

  frame_serializer u_dump_ser (
    .core_clk(core_clk),
    .srst(srst),
    .bit_en(bit_en_ff),
    .preamble(preamble),
    .load(dump_go),
    .payload(dump_pay),
    .len(DUMP_LEN),
    .busy(dump_busy),
    .bit_out(dump_bit)
  );

  frame_serializer u_phase_ser (
    .core_clk(core_clk),
    .srst(srst),
    .bit_en(bit_en_ff),
    .preamble(preamble),
    .load(phase_go),
    .payload(phase_pay),
    .len(PHASE_LEN),
    .busy(phase_busy),
    .bit_out(phase_bit)
  );

  always_ff @(posedge core_clk) begin
    if (srst) begin
      dump_req_ff <= 1'b0;
      phase_req_ff <= 1'b0;
      sync_ff <= 1'b0;
    end else begin
      if (dump_go)
        dump_req_ff <= 1'b0;
      else if (act_wr && wb_dat_i[ACT_DUMP] && !dump_busy)
        dump_req_ff <= 1'b1;
      if (phase_go)
        phase_req_ff <= 1'b0;
      else if (act_wr && wb_dat_i[ACT_PHASE] && !phase_busy)
        phase_req_ff <= 1'b1;
      if (dump_go)
        sync_ff <= dump_ff[2:0] == CMD_SYNC_TEST;
      else if (trg_ff == TRG_TWO && bit_en_ff)
        sync_ff <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Trigger: two 1 bits once the dump stream is free
  // ----------------------------------------------------------------
  logic trig_start;
  assign trig_start = !dump_busy && !dump_req_ff && preamble &&
                      (!sync_ff || ecnt_ff == ECNT_W'(EPOCH_LEN - 1));

  always_comb begin
    nxt_trg = trg_ff;
    unique case (trg_ff)
      TRG_IDLE: if (act_wr && wb_dat_i[ACT_TRIG]) nxt_trg = TRG_WAIT;
      TRG_WAIT: if (bit_en_ff && trig_start) nxt_trg = TRG_ONE;
      TRG_ONE: if (bit_en_ff) nxt_trg = TRG_TWO;
      TRG_TWO: if (bit_en_ff) nxt_trg = TRG_IDLE;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      trg_ff <= TRG_IDLE;
      dc_ff <= 1'b0;
      pm_ff <= 1'b0;
    end else begin
      trg_ff <= nxt_trg;
      if (bit_en_ff) begin
        dc_ff <= (nxt_trg == TRG_ONE || nxt_trg == TRG_TWO) ? 1'b1 : dump_bit;
        pm_ff <= phase_bit;
      end
    end
  end

  assign time_ref_stream = tc_ff;
  assign dump_control_stream = dc_ff;
  assign phase_model_stream = pm_ff;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  chk_tick_at_epoch: assert property (@(posedge core_clk) disable iff (srst)
    (bit_en_ff && epoch_slot) |=> time_ref_stream)
    else $error("tick bit missing at epoch");
  chk_idp_follows: assert property (@(posedge core_clk) disable iff (srst)
    (bit_en_ff && ecnt_ff == ECNT_W'(TC_IDP_SLOT)) |=> time_ref_stream == idp_lat_ff)
    else $error("identifier-present bit wrong");
  chk_seed_lsb: assert property (@(posedge core_clk) disable iff (srst)
    (bit_en_ff && ecnt_ff == ECNT_W'(TC_SEED0_SLOT)) |=> time_ref_stream == seed_lat_ff[0])
    else $error("first seed bit wrong");
  chk_bit_rate: assert property (@(posedge core_clk) disable iff (srst)
    bit_en_ff [*2] |=> !bit_en_ff)
    else $error("bit enable too dense");
  chk_bit_rate_min: assert property (@(posedge core_clk) disable iff (srst)
    !bit_en_ff [*2] |=> bit_en_ff)
    else $error("bit enable too sparse");
  chk_trigger_pair: assert property (@(posedge core_clk) disable iff (srst)
    (bit_en_ff && trg_ff == TRG_ONE) |=> dump_control_stream && $past(dump_control_stream))
    else $error("trigger not second 1 in a row");
  chk_sync_on_tick: assert property (@(posedge core_clk) disable iff (srst)
    (bit_en_ff && trg_ff == TRG_ONE && sync_ff) |-> epoch_slot)
    else $error("sync test trigger not on tick");
  chk_param_identity: assert property (@(posedge core_clk) disable iff (srst)
    (dump_go && dump_ff[2:0] == CMD_BLOCK_RESET) |-> dump_pay[26:11] == srcid_ff[15:0])
    else $error("source identity not in parameter field");
  chk_phase_align: assert property (@(posedge core_clk) disable iff (srst)
    phase_go |-> preamble && !phase_busy)
    else $error("phase frame off preamble phase");
  cov_dump_frame: cover property (@(posedge core_clk) disable iff (srst) dump_go);
  cov_phase_frame: cover property (@(posedge core_clk) disable iff (srst) phase_go);
  cov_trigger: cover property (@(posedge core_clk) disable iff (srst)
    trg_ff == TRG_TWO && bit_en_ff);
  cov_sync_trigger: cover property (@(posedge core_clk) disable iff (srst)
    trg_ff == TRG_ONE && sync_ff && bit_en_ff);

endmodule

// ---- tb/stream_rx_model.sv ----
/*
 Receiver model of the three control streams: learns the bit slots from
 time reference toggles, locks to the tick, decodes fields, records bits.
 Assumes all streams change together on the same bit slots.
*/
`timescale 1ns/100ps
module stream_rx_model
  import ctrl_stream_pkg::*;
#(
  parameter int EPOCH_LEN = 64,
  parameter int LEARN = 400
)
(
  input wire logic core_clk,
  input wire logic srst,
  input wire logic time_ref_stream,
  input wire logic dump_control_stream,
  input wire logic phase_model_stream,
  output logic locked,
  output int gslot,
  output logic id_present,
  output logic [7:0] seed0_act,
  output logic [7:0] seed1_act,
  output int ref_errs
);
  logic dump_rec [0:8191];
  logic phase_rec [0:8191];
  logic [24:0] mask;
  logic [3:0] hist;
  logic [15:0] seed_sh;
  logic prev_ref;
  int ph;
  int cyc;
  int slot;

  // ----------------------------------------------------------------
  // Slot recovery and decoding
  // ----------------------------------------------------------------
  task automatic take_bit();
    hist = {hist[2:0], time_ref_stream};
    if (!locked) begin
      locked = (hist == 4'b1011);
      slot = 0;
      gslot = 0;
    end else begin
      slot = (slot == EPOCH_LEN - 1) ? 0 : slot + 1;
      gslot = gslot + 1;
    end
    if (locked && gslot < 8192) begin
      dump_rec[gslot] = dump_control_stream;
      phase_rec[gslot] = phase_model_stream;
    end
    if (locked && slot == 0) begin
      if (time_ref_stream !== 1'b1)
        ref_errs = ref_errs + 1;
      seed0_act = seed_sh[7:0];
      seed1_act = seed_sh[15:8];
    end else if (locked && slot == 1)
      id_present = time_ref_stream;
    else if (locked && slot < TC_END_SLOT)
      seed_sh = {time_ref_stream, seed_sh[15:1]};
    else if (locked && time_ref_stream !== slot[0])
      ref_errs = ref_errs + 1;
  endtask

  // Slot phases repeat every 25 clocks (16 bits)
  always @(posedge core_clk) begin
    if (srst) begin
      mask = '0;
      hist = 4'h0;
      seed_sh = 16'h0;
      prev_ref = 1'b0;
      ph = 0;
      cyc = 0;
      slot = 0;
      gslot = 0;
      locked = 1'b0;
      id_present = 1'b0;
      seed0_act = 8'h0;
      seed1_act = 8'h0;
      ref_errs = 0;
    end else begin
      cyc = cyc + 1;
      if (cyc < LEARN && time_ref_stream !== prev_ref)
        mask[ph] = 1'b1;
      prev_ref = time_ref_stream;
      if (cyc >= LEARN && mask[ph])
        take_bit();
      ph = (ph == 24) ? 0 : ph + 1;
    end
  end
endmodule

// ---- tb/ctrl_stream_source_tb_top.sv ----
/*
 Testbench of the control stream source: Wishbone register checks and
 stream checks through the receiver model.
 Assumes a 200 MHz clock and a shortened epoch of 64 bits.
*/
`timescale 1ns/100ps
module ctrl_stream_source_tb_top
  import ctrl_stream_pkg::*;
;
  localparam int EPOCH = 64;
  localparam int MAX_CYCLES = 20000;
  logic core_clk, srst, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic [7:0] wb_adr_i, stn, seed0_act, seed1_act;
  logic [3:0] wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o, rd;
  logic [15:0] prm;
  logic time_ref_stream, dump_control_stream, phase_model_stream, locked, id_present;
  int gslot, ref_errs, from, mismatches, tests_run;
  int cycles = 0;
  logic [7:0] adrs [6] = '{REG_CTRL, REG_SEEDS, REG_DUMP, REG_PHASE, REG_PSEL, REG_SRCID};
  logic [31:0] msks [6] = '{32'h1, 32'hffff, 32'h07ff_ffff, 32'hffff_ffff, 32'hff, 32'hffff};

  ctrl_stream_source #(.EPOCH_LEN(EPOCH)) dut (.core_clk(core_clk), .srst(srst),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .time_ref_stream(time_ref_stream), .dump_control_stream(dump_control_stream),
    .phase_model_stream(phase_model_stream));
  stream_rx_model #(.EPOCH_LEN(EPOCH)) rx (.core_clk(core_clk), .srst(srst),
    .time_ref_stream(time_ref_stream), .dump_control_stream(dump_control_stream),
    .phase_model_stream(phase_model_stream), .locked(locked), .gslot(gslot),
    .id_present(id_present), .seed0_act(seed0_act), .seed1_act(seed1_act),
    .ref_errs(ref_errs));

  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end

  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == MAX_CYCLES) begin
      mismatches++;
      results();
    end
  end

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic results();
    $display("Comparisons %0d, mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic check_word(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR %0t: word %h, expected %h", $time, got, exp);
    end
  endtask

  task automatic check_flag(input logic got, input logic exp);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR %0t: flag %b, expected %b", $time, got, exp);
    end
  endtask

  task automatic wb_xfer(input logic we, input logic [7:0] adr, input logic [31:0] dat,
                         input logic [3:0] sel);
    @(posedge core_clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= adr;
    wb_sel_i <= sel;
    wb_dat_i <= dat;
    do
      @(posedge core_clk);
    while (wb_ack_o !== 1'b1);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask

  task automatic wb_write(input logic [7:0] adr, input logic [31:0] dat);
    wb_xfer(1'b1, adr, dat, 4'hf);
  endtask

  task automatic read_check(input logic [7:0] adr, input logic [31:0] exp);
    wb_xfer(1'b0, adr, 32'h0, 4'hf);
    check_word(rd, exp);
  endtask

  task automatic wait_slot(input int n);
    for (int i = 0; i < MAX_CYCLES && gslot < n; i++)
      @(posedge core_clk);
  endtask

  function automatic logic rec(input logic ph, input int i);
    rec = ph ? rx.phase_rec[i] : rx.dump_rec[i];
  endfunction

  // Start bit at an even slot, payload, check bits, four preamble bits
  task automatic check_frame(input logic ph, input logic [39:0] pay, input int n);
    logic [3:0] c;
    logic [3:0] r;
    logic [48:0] exp;
    logic fb;
    logic hit;
    logic ok;
    c = 4'h0;
    exp = '0;
    exp[0] = 1'b1;
    hit = 1'b0;
    for (int i = 0; i < n + 4; i++) begin
      fb = c[3];
      c = {c[2], c[1], c[0] ^ fb, ((i < n) ? pay[i] : 1'b0) ^ fb};
      if (i < n)
        exp[i + 1] = pay[i];
    end
    for (int i = 0; i < 4; i++)
      exp[n + 1 + i] = c[3 - i];
    wait_slot(from + n + 20);
    for (int s = from - 2; s <= from + 8; s++) begin
      ok = (s % 2 == 0);
      r = 4'h0;
      for (int i = 0; i < n + 9; i++) begin
        if (rec(ph, s + i) !== ((i < n + 5) ? exp[i] : 1'((s + i) % 2)))
          ok = 1'b0;
        if (i > 0 && i < n + 5)
          r = {r[2], r[1], r[0] ^ r[3], rec(ph, s + i) ^ r[3]};
      end
      hit = hit | (ok && r == 4'h0);
    end
    check_flag(hit, 1'b1);
  endtask

  // First pair of ones must start at an odd slot, its second one on the tick if armed
  task automatic check_trig(input logic sync_test_command);
    logic hit;
    logic done;
    int t;
    hit = 1'b0;
    done = 1'b0;
    t = (from / EPOCH + 1) * EPOCH;
    wait_slot(t + EPOCH + 4);
    for (int s = from - 2; s <= t + EPOCH; s++) begin
      if (!done && rec(1'b0, s) === 1'b1 && rec(1'b0, s + 1) === 1'b1) begin
        hit = (s % 2 == 1) && (sync_test_command ? ((s + 1) % EPOCH == 0) : (s <= from + 8));
        done = 1'b1;
      end
    end
    check_flag(hit, 1'b1);
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    srst = 1'b1;
    wb_cyc_i = 1'b0;
    wb_stb_i = 1'b0;
    wb_we_i = 1'b0;
    wb_adr_i = 8'h0;
    wb_sel_i = 4'h0;
    wb_dat_i = 32'h0;
    mismatches = 0;
    tests_run = 0;
    repeat (20) @(posedge core_clk);
    srst <= 1'b0;
    for (int a = 0; a < 40; a += 4)
      read_check(8'(a), RST_WORD);
    for (int k = 0; k < 6; k++) begin
      wb_write(adrs[k], 32'hffff_ffff);
      read_check(adrs[k], msks[k]);
      wb_write(adrs[k], 32'h0);
    end
    wb_xfer(1'b1, REG_PHASE, 32'h0000_5a00, 4'h2);
    wb_xfer(1'b1, REG_PHASE, 32'h1234_ffff, 4'h8);
    read_check(REG_PHASE, 32'h1200_5a00);
    wb_write(REG_STATUS, 32'hffff_ffff);
    wb_write(8'h20, 32'hffff_ffff);
    read_check(REG_STATUS, 32'h0);
    read_check(REG_ACTION, 32'h0);
    read_check(8'h20, 32'h0);
    for (int i = 0; i < 4000 && !locked; i++)
      @(posedge core_clk);
    check_flag(locked, 1'b1);
    wb_write(REG_CTRL, 32'h1);
    wb_write(REG_SEEDS, 32'h0000_3ca5);
    from = gslot;
    wait_slot(from + 3 * EPOCH);
    check_flag(id_present, 1'b1);
    check_word({16'h0, seed1_act, seed0_act}, 32'h0000_3ca5);
    wb_write(REG_SRCID, 32'h0000_9abc);
    for (int k = 0; k < 8; k++) begin
      stn = (k == 2) ? 8'hff : 8'(8'h10 + k);
      prm = 16'hc3a0 + 16'(k);
      wb_write(REG_DUMP, {5'h0, prm, stn, 3'(k)});
      wb_write(REG_ACTION, 32'h1 << ACT_DUMP);
      from = gslot;
      wb_xfer(1'b0, REG_STATUS, 32'h0, 4'hf);
      check_flag(rd[0] | rd[3], 1'b1);
      check_frame(1'b0, {13'h0, (k == 6) ? 16'h9abc : prm, stn, 3'(k)}, 27);
      if (k == 5 || k == 7) begin
        wb_write(REG_ACTION, 32'h1 << ACT_TRIG);
        from = gslot;
        check_trig(k == 7);
      end
    end
    wb_write(REG_PSEL, 32'h0000_005a);
    wb_write(REG_PHASE, 32'h8001_7ffe);
    wb_write(REG_ACTION, 32'h1 << ACT_PHASE);
    from = gslot;
    check_frame(1'b1, 40'h8001_7ffe_5a, 40);
    wb_write(REG_CTRL, 32'h0);
    from = gslot;
    wait_slot(from + 3 * EPOCH);
    check_flag(id_present, 1'b0);
    check_word(32'(ref_errs), 32'h0);
    results();
  end
endmodule
